//--- shared/oscsel_consts.svh
// Purpose: Constants for the oscillator select and clock divider block
// Assumes: AHB-Lite word registers, 16-bit data in the low half
// Notes: Contract list follows
//
// Contract
// - Power-on clock mode comes from initial source config; 111 is fast RC divide-by-N.
// - Primary modes take submode config: 10 high-speed, 01 crystal, 00 external.
// - Current source field, bits 14-12, read-only, shows source in use.
// - Requested source field bits 10-8, eight codes, power-on value from config.
// - Source lock bit 7 blocks switching when switch enabled, monitor off.
// - Pin select lock bit 6 set rejects pin select register writes.
// - PLL lock bit 5 reads 1 when locked or start-up timer elapsed; code has no timer, shows lock input only with a PLL source or a switch running.
// - Clock fail bit 3 set by monitor; software reads and clears it.
// - Secondary oscillator enable bit 1 turns secondary oscillator on or off; code keeps it on while secondary is the current source.
// - Switch request bit 0 starts switch; hardware clears it when done.
// - Oscillator control writes accepted only after unlock sequence.
// - Recover bit 15 set lets any interrupt clear reduction enable.
// - Reduction field bits 14-12 divides processor clock by two to the code; default 011.
// - Reduction enable bit 11 applies ratio; clear forces 1:1.
// - Fast RC postscale bits 10-8: 1 to 64 for 000-110, 256 for 111.
// - VCO divider bits 7-6: 00 by 2, 01 by 4 default, 11 by 8.
// - Input prescaler bits 4-0 divides by code plus two.
// - Unimplemented bits read as zero.
// - Instruction clock is oscillator output divided by two.
// - Multiplier from 9-bit feedback field equals code plus two; default 50.
// - Valid switch clears lock and fail, waits ready, 10 cycles, switches, clears request.
// - Switch config unprogrammed disables switching; request held 0.
`ifndef OSCSEL_CONSTS_SVH
`define OSCSEL_CONSTS_SVH
`define OSCSEL_ADDR_OSC_CTRL   32'h0000_0000
`define OSCSEL_ADDR_CLK_DIV    32'h0000_0004
`define OSCSEL_ADDR_FEEDBACK   32'h0000_0008
`define OSCSEL_ADDR_UNLOCK     32'h0000_000C
`define OSCSEL_UNLOCK_KEY1     16'h0046
`define OSCSEL_UNLOCK_KEY2     16'h0057
`define OSCSEL_CLK_DIV_RESET   16'h3040
`define OSCSEL_FEEDBACK_RESET  9'h030
`define OSCSEL_SRC_FAST_RC     3'h0
`define OSCSEL_SRC_FAST_RC_PLL 3'h1
`define OSCSEL_SRC_PRI         3'h2
`define OSCSEL_SRC_PRI_PLL     3'h3
`define OSCSEL_SRC_SEC         3'h4
`define OSCSEL_SETTLE_CYCLES   4'hA
`define OSCSEL_CNT_ONE         4'h1
`define OSCSEL_VCO_RESERVED    2'h2
`define OSCSEL_CC_CUR_HI       14
`define OSCSEL_CC_CUR_LO       12
`define OSCSEL_CC_REQ_HI       10
`define OSCSEL_CC_REQ_LO       8
`define OSCSEL_CC_SRC_LOCK     7
`define OSCSEL_CC_PIN_LOCK     6
`define OSCSEL_CC_PLL_LOCK     5
`define OSCSEL_CC_FAIL         3
`define OSCSEL_CC_SEC_ON       1
`define OSCSEL_CC_SWITCH       0
`define OSCSEL_CD_RECOVER      15
`define OSCSEL_CD_RED_EN       11
`define OSCSEL_HTRANS_NONSEQ   2'h2
`endif

//--- shared/oscsel_pkg.sv
// Purpose: Types for the oscillator select and clock divider block
// Assumes: Constants header holds the numbers
// Notes: Packed carriers only
package oscsel_pkg;
	typedef struct packed {
		logic        recover_on_irq;
		logic [2:0]  proc_clock_reduction;
		logic        reduction_enable;
		logic [2:0]  fast_rc_postscale;
		logic [1:0]  vco_out_divider;
		logic        unused_bit;
		logic [4:0]  phase_input_divider;
	} oscsel_clk_div_t;
	typedef struct packed {
		logic        enable;
		logic [2:0]  source;
		logic [1:0]  submode;
		logic [7:0]  proc_div;
		logic [8:0]  fast_rc_div;
		logic [3:0]  vco_div;
		logic [5:0]  input_div;
		logic [9:0]  multiplier;
	} oscsel_clk_cfg_t;
	typedef enum logic [1:0] {
		OSCSEL_IDLE,
		OSCSEL_WAIT_READY,
		OSCSEL_SETTLE
	} oscsel_state_t;
endpackage

//--- core/oscsel_top.sv
// Purpose: Oscillator source selection and clock divider control registers
// Assumes: AHB-Lite slave, zero wait states, OKAY always
// Notes: Analog oscillators sit outside; readiness arrives on inputs
`timescale 1ns/1ns
`include "oscsel_consts.svh"
module oscsel_top (
	input  wire logic                    clk_in,
	input  wire logic                    nrst_in,
	input  wire logic                    hsel_in,
	input  wire logic [31:0]             haddr_in,
	input  wire logic [1:0]              htrans_in,
	input  wire logic                    hwrite_in,
	input  wire logic [2:0]              hsize_in,
	input  wire logic [31:0]             hwdata_in,
	input  wire logic                    hready_in,
	output logic      [31:0]             hrdata_out,
	output logic                         hreadyout_out,
	output logic                         hresp_out,
	input  wire logic [2:0]              initial_source_cfg_in,
	input  wire logic [1:0]              primary_submode_cfg_in,
	input  wire logic [1:0]              switch_monitor_cfg_in,
	input  wire logic                    osc_ready_in,
	input  wire logic                    pll_locked_in,
	input  wire logic                    clock_fail_in,
	input  wire logic                    new_source_tick_in,
	input  wire logic                    irq_in,
	output oscsel_pkg::oscsel_clk_cfg_t  clk_cfg_out,
	output logic      [2:0]              start_source_out,
	output logic                         start_source_en_out,
	output logic                         secondary_osc_on_out,
	output logic                         pin_select_lock_out
);
	logic [2:0]                  current_source_sel_q;
	logic [2:0]                  requested_source_sel_q;
	logic                        source_lock_q;
	logic                        pin_select_lock_q;
	logic                        pll_lock_q;
	logic                        clock_fail_flag_q;
	logic                        secondary_osc_on_q;
	logic                        switch_request_q;
	oscsel_pkg::oscsel_clk_div_t clk_div_q;
	logic [8:0]                  feedback_multiplier_q;
	logic [1:0]                  submode_q;
	logic                        cfg_loaded_q;
	logic [1:0]                  unlock_q;
	oscsel_pkg::oscsel_state_t   state_q;
	logic [3:0]                  settle_q;
	logic                        wr_pend_q;
	logic [31:0]                 wr_addr_q;
	logic                        switch_enabled;
	logic                        monitor_enabled;
	logic                        bus_take;
	logic                        wr_osc;
	logic                        wr_div;
	logic                        wr_fb;
	logic                        wr_key;
	logic [15:0]                 wdata;
	logic                        switch_start;
	logic                        switch_done;
	logic                        req_redundant;

	function automatic logic [15:0] osc_ctrl_word(input logic [2:0] cur, input logic [2:0] req,
		input logic s_lock, input logic p_lock, input logic plk, input logic fail,
		input logic sec, input logic sw);
		osc_ctrl_word = {1'b0, cur, 1'b0, req, s_lock, p_lock, plk, 1'b0, fail, 1'b0, sec, sw};
	endfunction

	function automatic logic [8:0] pow2(input logic [2:0] code);
		pow2 = 9'h001 << code;
	endfunction

	assign switch_enabled  = ~switch_monitor_cfg_in[1];
	assign monitor_enabled = switch_monitor_cfg_in == 2'h0;
	assign bus_take        = hsel_in & hready_in & (htrans_in == `OSCSEL_HTRANS_NONSEQ);
	assign wdata           = hwdata_in[15:0];
	assign wr_osc          = wr_pend_q & (wr_addr_q == `OSCSEL_ADDR_OSC_CTRL) & (unlock_q == 2'h2);
	assign wr_div          = wr_pend_q & (wr_addr_q == `OSCSEL_ADDR_CLK_DIV);
	assign wr_fb           = wr_pend_q & (wr_addr_q == `OSCSEL_ADDR_FEEDBACK);
	assign wr_key          = wr_pend_q & (wr_addr_q == `OSCSEL_ADDR_UNLOCK);
	assign req_redundant   = requested_source_sel_q == current_source_sel_q;
	assign switch_start    = (state_q == oscsel_pkg::OSCSEL_IDLE) & switch_request_q
		& ~req_redundant & ~(source_lock_q & (switch_monitor_cfg_in == 2'h1));
	assign switch_done     = (state_q == oscsel_pkg::OSCSEL_SETTLE) & new_source_tick_in
		& (settle_q == `OSCSEL_CNT_ONE);
	assign hreadyout_out   = 1'b1;
	assign hresp_out       = 1'b0;

	// Bus write capture for the data phase
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= bus_take & hwrite_in;
			wr_addr_q <= haddr_in;
		end
	end

	// Read data register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (bus_take & ~hwrite_in) begin
			unique case (haddr_in)
				`OSCSEL_ADDR_OSC_CTRL: hrdata_out <= {16'h0000, osc_ctrl_word(current_source_sel_q,
					requested_source_sel_q, source_lock_q, pin_select_lock_q, pll_lock_q,
					clock_fail_flag_q, secondary_osc_on_q, switch_request_q)};
				`OSCSEL_ADDR_CLK_DIV:  hrdata_out <= {16'h0000, clk_div_q & 16'hFFDF};
				`OSCSEL_ADDR_FEEDBACK: hrdata_out <= {23'h00_0000, feedback_multiplier_q};
				default:               hrdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Unlock sequence: two keys, then one control write
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			unlock_q <= 2'h0;
		end else if (wr_key & (wdata == `OSCSEL_UNLOCK_KEY1)) begin
			unlock_q <= 2'h1;
		end else if (wr_key & (unlock_q == 2'h1) & (wdata == `OSCSEL_UNLOCK_KEY2)) begin
			unlock_q <= 2'h2;
		end else if (wr_pend_q) begin
			unlock_q <= 2'h0;
		end
	end

	// Configuration capture after reset release
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg_loaded_q <= 1'b0;
			submode_q    <= 2'h0;
		end else if (!cfg_loaded_q) begin
			cfg_loaded_q <= 1'b1;
			submode_q    <= primary_submode_cfg_in;
		end
	end

	// Source selection fields
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			current_source_sel_q   <= 3'h7;
			requested_source_sel_q <= 3'h7;
		end else if (!cfg_loaded_q) begin
			current_source_sel_q   <= initial_source_cfg_in;
			requested_source_sel_q <= initial_source_cfg_in;
		end else begin
			if (wr_osc & switch_enabled)
				requested_source_sel_q <= wdata[`OSCSEL_CC_REQ_HI:`OSCSEL_CC_REQ_LO];
			if (switch_done)
				current_source_sel_q <= requested_source_sel_q;
		end
	end

	// Lock bits and secondary enable
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			source_lock_q      <= 1'b0;
			pin_select_lock_q  <= 1'b0;
			secondary_osc_on_q <= 1'b0;
		end else if (wr_osc) begin
			source_lock_q      <= wdata[`OSCSEL_CC_SRC_LOCK];
			pin_select_lock_q  <= wdata[`OSCSEL_CC_PIN_LOCK];
			secondary_osc_on_q <= wdata[`OSCSEL_CC_SEC_ON];
		end
	end

	// Switch request: software sets, hardware clears
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			switch_request_q <= 1'b0;
		end else if (!switch_enabled) begin
			switch_request_q <= 1'b0;
		end else if (switch_done | (switch_request_q & req_redundant
			& (state_q == oscsel_pkg::OSCSEL_IDLE))) begin
			switch_request_q <= 1'b0;
		end else if (wr_osc & wdata[`OSCSEL_CC_SWITCH]) begin
			switch_request_q <= 1'b1;
		end
	end

	// Clock fail flag; a new failure wins over a clear
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clock_fail_flag_q <= 1'b0;
		end else if (clock_fail_in & monitor_enabled) begin
			clock_fail_flag_q <= 1'b1;
		end else if (switch_start | (wr_osc & ~wdata[`OSCSEL_CC_FAIL])) begin
			clock_fail_flag_q <= 1'b0;
		end
	end

	// PLL lock status
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pll_lock_q <= 1'b0;
		end else if (switch_start) begin
			pll_lock_q <= 1'b0;
		end else begin
			pll_lock_q <= pll_locked_in & ((current_source_sel_q == `OSCSEL_SRC_FAST_RC_PLL)
				| (current_source_sel_q == `OSCSEL_SRC_PRI_PLL)
				| (state_q != oscsel_pkg::OSCSEL_IDLE));
		end
	end

	// Switch sequencer
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q  <= oscsel_pkg::OSCSEL_IDLE;
			settle_q <= 4'h0;
		end else begin
			unique case (state_q)
				oscsel_pkg::OSCSEL_IDLE: begin
					if (switch_start)
						state_q <= oscsel_pkg::OSCSEL_WAIT_READY;
				end
				oscsel_pkg::OSCSEL_WAIT_READY: begin
					if (osc_ready_in & (pll_locked_in
						| ((requested_source_sel_q != `OSCSEL_SRC_FAST_RC_PLL)
						& (requested_source_sel_q != `OSCSEL_SRC_PRI_PLL)))) begin
						state_q  <= oscsel_pkg::OSCSEL_SETTLE;
						settle_q <= `OSCSEL_SETTLE_CYCLES;
					end
				end
				oscsel_pkg::OSCSEL_SETTLE: begin
					if (new_source_tick_in) begin
						settle_q <= settle_q - `OSCSEL_CNT_ONE;
						if (settle_q == `OSCSEL_CNT_ONE)
							state_q <= oscsel_pkg::OSCSEL_IDLE;
					end
				end
			endcase
		end
	end

	// Clock divisor register and recover on interrupt
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clk_div_q <= `OSCSEL_CLK_DIV_RESET;
		end else begin
			if (wr_div) begin
				clk_div_q <= wdata;
				if (wdata[7:6] == `OSCSEL_VCO_RESERVED)
					clk_div_q.vco_out_divider <= clk_div_q.vco_out_divider;
			end
			if (irq_in & clk_div_q.recover_on_irq)
				clk_div_q.reduction_enable <= 1'b0;
		end
	end

	// Feedback multiplier register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			feedback_multiplier_q <= `OSCSEL_FEEDBACK_RESET;
		end else if (wr_fb) begin
			feedback_multiplier_q <= hwdata_in[8:0];
		end
	end

	// Decoded clock configuration outputs
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clk_cfg_out          <= '0;
			start_source_out     <= 3'h0;
			start_source_en_out  <= 1'b0;
			secondary_osc_on_out <= 1'b0;
			pin_select_lock_out  <= 1'b0;
		end else begin
			clk_cfg_out.enable      <= cfg_loaded_q;
			clk_cfg_out.source      <= current_source_sel_q;
			clk_cfg_out.submode     <= submode_q;
			clk_cfg_out.proc_div    <= clk_div_q.reduction_enable
				? 8'(pow2(clk_div_q.proc_clock_reduction)) : 8'h01;
			clk_cfg_out.fast_rc_div <= (clk_div_q.fast_rc_postscale == 3'h7)
				? 9'h100 : pow2(clk_div_q.fast_rc_postscale);
			clk_cfg_out.vco_div     <= (clk_div_q.vco_out_divider == 2'h3)
				? 4'h8 : 4'(pow2({1'b0, clk_div_q.vco_out_divider} + 3'h1));
			clk_cfg_out.input_div   <= {1'b0, clk_div_q.phase_input_divider} + 6'h02;
			clk_cfg_out.multiplier  <= {1'b0, feedback_multiplier_q} + 10'h002;
			start_source_out        <= requested_source_sel_q;
			start_source_en_out     <= state_q != oscsel_pkg::OSCSEL_IDLE;
			secondary_osc_on_out    <= secondary_osc_on_q | (current_source_sel_q == `OSCSEL_SRC_SEC);
			pin_select_lock_out     <= pin_select_lock_q;
		end
	end
	// Instruction clock is oscillator over two, applied by the clock tree
	// Direct PLL to PLL switches are software's duty
endmodule

//--- dv/oscsel_checker.sv
// Purpose: Port assertions for oscsel_top
// Assumes: Config inputs only change while reset is low
// Notes: Bound into oscsel_top below
`timescale 1ns/1ns
module oscsel_checker (
	input wire logic                   clk_in,
	input wire logic                   nrst_in,
	input wire logic [2:0]             initial_source_cfg_in,
	input wire logic [1:0]             switch_monitor_cfg_in,
	input wire logic                   osc_ready_in,
	input wire oscsel_pkg::oscsel_clk_cfg_t clk_cfg_out,
	input wire logic [2:0]             start_source_out,
	input wire logic                   start_source_en_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_src_power_on: assert property ($rose(nrst_in) |-> ##2
		clk_cfg_out.source == $past(initial_source_cfg_in, 2)) else $error("power-on source wrong");
	a_src_only_switch: assert property ($past(nrst_in, 3) && $changed(clk_cfg_out.source)
		|-> $past(start_source_en_out)) else $error("source changed outside a switch");
	a_switch_done: assert property ($fell(start_source_en_out) |->
		clk_cfg_out.source == start_source_out) else $error("switch ended without new source");
	a_wait_ready: assert property (start_source_en_out && !osc_ready_in |=>
		start_source_en_out) else $error("switch finished before source ready");
	a_switch_off: assert property (switch_monitor_cfg_in[1] |-> !start_source_en_out)
		else $error("switch started while switching disabled");
	a_vco_div: assert property ($past(nrst_in, 2) |->
		clk_cfg_out.vco_div inside {4'h2, 4'h4, 4'h8}) else $error("vco divider out of set");
	a_input_div: assert property ($past(nrst_in, 2) |->
		clk_cfg_out.input_div inside {[6'h02:6'h21]}) else $error("input divider out of range");
	a_mult_range: assert property ($past(nrst_in, 2) |->
		clk_cfg_out.multiplier inside {[10'h002:10'h201]}) else $error("multiplier out of range");
	a_fast_rc_div: assert property ($past(nrst_in, 2) |->
		$onehot(clk_cfg_out.fast_rc_div) && !clk_cfg_out.fast_rc_div[7])
		else $error("fast rc divider not legal");
	a_proc_div: assert property ($past(nrst_in, 2) |-> $onehot(clk_cfg_out.proc_div))
		else $error("processor divider not a power of two");
endmodule
bind oscsel_top oscsel_checker chk (.clk_in(clk_in), .nrst_in(nrst_in),
	.initial_source_cfg_in(initial_source_cfg_in), .switch_monitor_cfg_in(switch_monitor_cfg_in),
	.osc_ready_in(osc_ready_in), .clk_cfg_out(clk_cfg_out), .start_source_out(start_source_out),
	.start_source_en_out(start_source_en_out));

//--- dv/osc_select_clock_divider_tb.sv
// Purpose: Self-checking bench for oscsel_top
// Assumes: Zero wait state slave, offsets and keys from constants header
// Notes: Reads checked by a monitor against a queue of expectations
`timescale 1ns/1ns
`include "oscsel_consts.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module osc_select_clock_divider_tb;
	localparam logic [31:0] R_OSC = `OSCSEL_ADDR_OSC_CTRL;
	localparam logic [31:0] R_DIV = `OSCSEL_ADDR_CLK_DIV;
	localparam logic [31:0] R_FB = `OSCSEL_ADDR_FEEDBACK;
	logic        clk_in = 1'b0, nrst_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, pend = 1'b0;
	logic        ready = 1'b0, pll = 1'b0, fail = 1'b0, tick = 1'b0, irq = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, d, exv;
	logic [1:0]  htrans = '0, scfg = 2'h2, mcfg = 2'h1;
	logic [2:0]  icfg = 3'h7, ssrc;
	logic        hrdy, sen, sec, plock, hresp;
	logic [15:0] e, cdm;
	logic [36:0] dv;
	logic [31:0] expq[$];
	int          bad_count = 0, check_count = 0, seed = 32'hb8de_e7cb;
	oscsel_pkg::oscsel_clk_cfg_t cfg;
	always #5 clk_in = ~clk_in;
	oscsel_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
		.initial_source_cfg_in(icfg), .primary_submode_cfg_in(scfg),
		.switch_monitor_cfg_in(mcfg), .osc_ready_in(ready), .pll_locked_in(pll),
		.clock_fail_in(fail), .new_source_tick_in(tick), .irq_in(irq), .clk_cfg_out(cfg),
		.start_source_out(ssrc), .start_source_en_out(sen),
		.secondary_osc_on_out(sec), .pin_select_lock_out(plock));
	always @(posedge clk_in) begin
		if (pend) begin
			exv = expq.pop_front();
			`CHK("hrdata", exv, hrdata)
			`CHK("hresp", 1'b0, hresp)
		end
		pend <= hsel && htrans == `OSCSEL_HTRANS_NONSEQ && !hwrite;
	end
	task automatic close_out;
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] dt);
		int n;
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= `OSCSEL_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge clk_in);
				n++;
			end while (hrdy !== 1'b1 && n < 64);
			if (n >= 64) begin
				bad_count++;
				close_out();
			end
			hsel <= 1'b0;
			htrans <= '0;
			hwdata <= dt;
		end
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] ex);
		expq.push_back(ex);
		xfer(1'b0, a, '0);
	endtask
	task automatic wosc(input logic [15:0] v);
		xfer(1'b1, `OSCSEL_ADDR_UNLOCK, {16'h0000, `OSCSEL_UNLOCK_KEY1});
		xfer(1'b1, `OSCSEL_ADDR_UNLOCK, {16'h0000, `OSCSEL_UNLOCK_KEY2});
		xfer(1'b1, R_OSC, {16'h0000, v});
	endtask
	task automatic ticks(input int k);
		repeat (k) begin
			@(posedge clk_in);
			tick <= 1'b1;
			@(posedge clk_in);
			tick <= 1'b0;
		end
		repeat (2) @(posedge clk_in);
	endtask
	task automatic rst(input logic [2:0] i, input logic [1:0] s, input logic [1:0] m);
		@(posedge clk_in);
		nrst_in <= 1'b0;
		icfg <= i;
		scfg <= s;
		mcfg <= m;
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic pulse_irq;
		@(posedge clk_in);
		irq <= 1'b1;
		@(posedge clk_in);
		irq <= 1'b0;
	endtask
	initial begin
		rst(3'h7, 2'h2, 2'h1);
		`CHK("source", 3'h7, cfg.source)
		`CHK("submode", 2'h2, cfg.submode)
		`CHK("enable", 1'b1, cfg.enable)
		dv = {8'h01, 9'h001, 4'h4, 6'h02, 10'h032};
		`CHK("divs", dv, cfg[36:0])
		rd(R_OSC, 32'h0000_7700);
		rd(R_DIV, 32'h0000_3040);
		rd(R_FB, 32'h0000_0030);
		xfer(1'b1, R_OSC, 32'h0000_0042);
		rd(R_OSC, 32'h0000_7700);
		wosc(16'hffff);
		rd(R_OSC, 32'h0000_77c2);
		`CHK("pinlock", 1'b1, plock)
		`CHK("secon", 1'b1, sec)
		wosc(16'h0080);
		repeat (2) @(posedge clk_in);
		`CHK("pinlock", 1'b0, plock)
		`CHK("secon", 1'b0, sec)
		wosc(16'h0081);
		ticks(2);
		`CHK("busy", 1'b0, sen)
		wosc(16'h0000);
		rd(R_OSC, 32'h0000_7001);
		wosc(16'h0001);
		ticks(5);
		`CHK("busy", 1'b1, sen)
		`CHK("target", 3'h0, ssrc)
		@(posedge clk_in);
		ready <= 1'b1;
		ticks(9);
		`CHK("busy", 1'b1, sen)
		ticks(1);
		`CHK("busy", 1'b0, sen)
		rd(R_OSC, 32'h0000_0000);
		wosc(16'h0101);
		ticks(12);
		`CHK("busy", 1'b1, sen)
		@(posedge clk_in);
		pll <= 1'b1;
		ticks(10);
		rd(R_OSC, 32'h0000_1120);
		pll <= 1'b0;
		wosc(16'h0101);
		rd(R_OSC, 32'h0000_1100);
		cdm = 16'h3040;
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			d[14:8] = {i[2:0], 1'b1, i[2:0]};
			d[7:6] = i[1:0];
			e = d[15:0] & 16'hffdf;
			if (d[7:6] == `OSCSEL_VCO_RESERVED)
				e[7:6] = cdm[7:6];
			cdm = e;
			xfer(1'b1, R_DIV, d);
			rd(R_DIV, {16'h0000, e});
			dv = {8'h01 << i, (i == 7) ? 9'h100 : 9'h001 << i, e[7] ? 4'h8 : 4'h2 << e[6],
				{1'b0, e[4:0]} + 6'h02, 10'h032};
			`CHK("divs", dv, cfg[36:0])
		end
		xfer(1'b1, R_DIV, 32'h0000_b840);
		pulse_irq();
		rd(R_DIV, 32'h0000_b040);
		`CHK("procdiv", 8'h01, cfg.proc_div)
		xfer(1'b1, R_DIV, 32'h0000_3840);
		pulse_irq();
		rd(R_DIV, 32'h0000_3840);
		`CHK("procdiv", 8'h08, cfg.proc_div)
		xfer(1'b1, R_FB, 32'h0000_ffff);
		rd(R_FB, 32'h0000_01ff);
		`CHK("mult", 10'h201, cfg.multiplier)
		xfer(1'b1, 32'h0000_0010, 32'h0000_ffff);
		rd(32'h0000_0010, 32'h0000_0000);
		rst(3'h7, 2'h1, 2'h2);
		wosc(16'h0201);
		ticks(10);
		`CHK("busy", 1'b0, sen)
		`CHK("source", 3'h7, cfg.source)
		rst(3'h3, 2'h1, 2'h0);
		`CHK("source", 3'h3, cfg.source)
		`CHK("submode", 2'h1, cfg.submode)
		rd(R_OSC, 32'h0000_3300);
		pll <= 1'b1;
		fail <= 1'b1;
		@(posedge clk_in);
		fail <= 1'b0;
		rd(R_OSC, 32'h0000_3328);
		wosc(16'h0300);
		rd(R_OSC, 32'h0000_3320);
		close_out();
	end
endmodule
